// >>> hdl/dbd_pkg.sv
// constants, register map, opcodes and types of the branch/io/control decoder
// Operation
// - upper byte F7 is branch_no_overflow, taken without overflow, F0 branch_on_overflow, taken on overflow
// - upper byte F5 is branch_nonzero, F6 branch_zero; both are two words
// - upper byte FD copies data to data, FC program to data; two words
// - upper byte 56 is data_word_move; operand address from the low byte
// - word CE0E or CE0F is serial_format_set; bit 0 loads the format
// - nibble 8 is port input, E port output; next nibble picks the port
// - CE36 clears frame sync mode, CE37 sets it
// - CE20 clears transmit mode, CE21 sets it
// - upper byte 57 tests a bit whose position comes from the T register
// - CE04 maps the memory block to data space, CE05 to program space
// - upper byte 50 loads status register zero, 51 status register one
// - upper byte 78 stores status register zero, 79 status register one
// - CE1D pops stack into low accumulator; upper byte 7A pops to memory
// - CE1C pushes low accumulator; upper byte 54 pushes a memory word
// - upper byte 4B repeats from memory, CB from the immediate low byte
package dbd_pkg;

  // register map, byte addresses
  localparam logic [7:0]  REG_CTRL_OFS  = 8'h00;
  localparam logic [7:0]  REG_MODE_OFS  = 8'h04;
  localparam logic [7:0]  REG_LAST_OFS  = 8'h08;
  localparam logic [7:0]  REG_COUNT_OFS = 8'h0C;

  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_CLR_BIT  = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;

  localparam int          MODE_FMT_BIT  = 0;
  localparam int          MODE_FSM_BIT  = 1;
  localparam int          MODE_TXM_BIT  = 2;
  localparam int          MODE_CFG_BIT  = 3;
  localparam logic [3:0]  MODE_RST      = 4'h0;

  // opcode upper bytes
  localparam logic [7:0]  UB_BR_NO_OV   = 8'hF7;
  localparam logic [7:0]  UB_BR_ON_OV   = 8'hF0;
  localparam logic [7:0]  UB_BR_NZ      = 8'hF5;
  localparam logic [7:0]  UB_BR_Z       = 8'hF6;
  localparam logic [7:0]  UB_BLK_DD     = 8'hFD;
  localparam logic [7:0]  UB_BLK_PD     = 8'hFC;
  localparam logic [7:0]  UB_DMOVE      = 8'h56;
  localparam logic [7:0]  UB_BTRG       = 8'h57;
  localparam logic [7:0]  UB_SR0_LD     = 8'h50;
  localparam logic [7:0]  UB_SR1_LD     = 8'h51;
  localparam logic [7:0]  UB_SR0_SV     = 8'h78;
  localparam logic [7:0]  UB_SR1_SV     = 8'h79;
  localparam logic [7:0]  UB_POP_MEM    = 8'h7A;
  localparam logic [7:0]  UB_PUSH_MEM   = 8'h54;
  localparam logic [7:0]  UB_REP_MEM    = 8'h4B;
  localparam logic [7:0]  UB_REP_IMM    = 8'hCB;
  localparam logic [7:0]  UB_PREFIX     = 8'hCE;
  localparam logic [3:0]  NB_PORT_IN    = 4'h8;
  localparam logic [3:0]  NB_PORT_OUT   = 4'hE;

  // low bytes under the prefix
  localparam logic [6:0]  LB_FORMAT_HI  = 7'h07;
  localparam logic [7:0]  LB_FSM_CLR    = 8'h36;
  localparam logic [7:0]  LB_FSM_SET    = 8'h37;
  localparam logic [7:0]  LB_TXM_CLR    = 8'h20;
  localparam logic [7:0]  LB_TXM_SET    = 8'h21;
  localparam logic [7:0]  LB_CFG_DATA   = 8'h04;
  localparam logic [7:0]  LB_CFG_PROG   = 8'h05;
  localparam logic [7:0]  LB_POP_ACC    = 8'h1D;
  localparam logic [7:0]  LB_PUSH_ACC   = 8'h1C;

  localparam logic [1:0]  PC_INC_ONE    = 2'h1;
  localparam logic [1:0]  PC_INC_TWO    = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE, OP_BRANCH_NO_OVERFLOW, OP_BRANCH_ON_OVERFLOW, OP_BRANCH_NONZERO,
    OP_BRANCH_ZERO, OP_BLOCK_COPY_DATA_TO_DATA, OP_BLOCK_COPY_PROG_TO_DATA,
    OP_DATA_WORD_MOVE, OP_SERIAL_FORMAT_SET, OP_PORT_INPUT, OP_PORT_OUTPUT,
    OP_FRAME_SYNC_MODE_CLEAR, OP_FRAME_SYNC_MODE_SET, OP_TRANSMIT_MODE_CLEAR,
    OP_TRANSMIT_MODE_SET, OP_BIT_TEST_BY_TREG, OP_BLOCK_TO_DATA_SPACE,
    OP_BLOCK_TO_PROGRAM_SPACE, OP_STATUS0_LOAD, OP_STATUS1_LOAD, OP_STATUS0_STORE,
    OP_STATUS1_STORE, OP_STACK_POP_TO_ACC, OP_STACK_POP_TO_MEM, OP_STACK_PUSH_ACC,
    OP_STACK_PUSH_MEM, OP_REPEAT_FROM_MEM, OP_REPEAT_FROM_IMMEDIATE
  } dbd_op_type;

  typedef enum logic {
    ST_OPCODE  = 1'b0,
    ST_EXTWORD = 1'b1
  } dbd_state_type;

endpackage

// >>> hdl/dbd_ahb_slave.sv
// zero-wait AHB-Lite slave front end for the decoder registers
module dbd_ahb_slave
  import dbd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // register side
  output logic      [7:0]  rd_addr,
  input  wire logic [31:0] rd_data,
  output logic             wr_en,
  output logic      [7:0]  wr_addr,
  output logic      [31:0] wr_data
);

  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  addr_r,    addr_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic        addr_phase;

  // read data sampled at the address phase so it leaves a flip-flop
  always_comb begin
    addr_phase  = hsel && htrans[1] && hready;
    wr_pend_nxt = addr_phase && hwrite;
    addr_nxt    = addr_phase ? haddr : addr_r;
    rdata_nxt   = (addr_phase && !hwrite) ? rd_data : rdata_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      addr_r    <= addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign rd_addr   = haddr;
  assign wr_en     = wr_pend_r;
  assign wr_addr   = addr_r;
  assign wr_data   = hwdata;
  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// >>> hdl/dbd_addr_mode.sv
// direct or indirect operand addressing split of an opcode low byte, for single-word and held two-word opcodes
module dbd_addr_mode (
  // opcode low byte
  input  wire logic [7:0] low_byte,
  // decoded addressing
  output logic            indirect,
  output logic      [6:0] operand
);

  always_comb begin
    indirect = low_byte[7];
    operand  = low_byte[6:0];
  end

endmodule

// >>> hdl/dbd_decoder.sv
// branch, move, port, serial-mode and control opcode decoder with register slave
module dbd_decoder
  import dbd_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // register bus
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // instruction words from program memory
  input  wire logic [15:0] IWORD,
  input  wire logic        IWORD_VALID,
  output logic             IWORD_READY,
  // datapath conditions
  input  wire logic        OV_FLAG,
  input  wire logic        ACC_ZERO,
  input  wire logic [3:0]  TREG_BIT,
  // decoded controls
  output logic             DEC_VALID,
  output logic      [4:0]  DEC_OP,
  output logic      [1:0]  DEC_PC_INC,
  output logic      [15:0] DEC_EXT_WORD,
  output logic             DEC_INDIRECT,
  output logic      [6:0]  DEC_OPERAND,
  output logic      [3:0]  DEC_PORT,
  output logic      [7:0]  DEC_IMM,
  output logic      [3:0]  DEC_BIT_SEL,
  output logic             BRANCH_TAKE,
  output logic             REPEAT_LOAD,
  // serial port and memory modes
  output logic             SERIAL_FORMAT,
  output logic             FRAME_SYNC_MODE,
  output logic             TRANSMIT_MODE,
  output logic             BLOCK_PROGRAM_SPACE
);

  // bus side
  logic [7:0]    rd_addr;
  logic [31:0]   rd_data;
  logic          wr_en;
  logic [7:0]    wr_addr;
  logic [31:0]   wr_data;

  // register state
  logic [1:0]    ctrl_r,     ctrl_nxt;
  logic [3:0]    mode_r,     mode_nxt;
  logic [31:0]   count_r,    count_nxt;

  // sequencing
  dbd_state_type state_r,    state_nxt;
  dbd_op_type    hold_op_r,  hold_op_nxt;
  logic [15:0]   hold_word_r, hold_word_nxt;

  // decoded outputs
  logic          valid_r,    valid_nxt;
  dbd_op_type    op_r,       op_nxt;
  logic [1:0]    inc_r,      inc_nxt;
  logic [15:0]   ext_r,      ext_nxt;
  logic          ind_r,      ind_nxt;
  logic [6:0]    oper_r,     oper_nxt;
  logic [3:0]    port_r,     port_nxt;
  logic [7:0]    imm_r,      imm_nxt;
  logic [3:0]    bitsel_r,   bitsel_nxt;
  logic          take_r,     take_nxt;
  logic          rep_r,      rep_nxt;

  // combinational helpers
  logic          accept;
  logic          am_indirect;
  logic [6:0]    am_operand;
  dbd_op_type    word_op;
  logic          word_two;
  logic [7:0]    ub;
  logic [7:0]    lb;

  dbd_ahb_slave u_slave (
    .clk       (CLK),
    .rst_n     (RST_N),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // held opcode low byte in the extension state, else the incoming one
  dbd_addr_mode u_addr (
    .low_byte (state_r == ST_EXTWORD ? hold_word_r[7:0] : IWORD[7:0]),
    .indirect (am_indirect),
    .operand  (am_operand)
  );

  assign ub          = IWORD[15:8];
  assign lb          = IWORD[7:0];
  // disabling the decoder stalls program memory instead of dropping words
  assign IWORD_READY = ctrl_r[CTRL_EN_BIT];
  assign accept      = IWORD_VALID && IWORD_READY;

  // classify one incoming opcode word
  always_comb begin
    word_op  = OP_NONE;
    word_two = 1'b0;
    if (ub == UB_PREFIX) begin
      if (lb[7:1] == LB_FORMAT_HI) word_op = OP_SERIAL_FORMAT_SET;
      else if (lb == LB_FSM_CLR) word_op = OP_FRAME_SYNC_MODE_CLEAR;
      else if (lb == LB_FSM_SET) word_op = OP_FRAME_SYNC_MODE_SET;
      else if (lb == LB_TXM_CLR) word_op = OP_TRANSMIT_MODE_CLEAR;
      else if (lb == LB_TXM_SET) word_op = OP_TRANSMIT_MODE_SET;
      else if (lb == LB_CFG_DATA) word_op = OP_BLOCK_TO_DATA_SPACE;
      else if (lb == LB_CFG_PROG) word_op = OP_BLOCK_TO_PROGRAM_SPACE;
      else if (lb == LB_POP_ACC) word_op = OP_STACK_POP_TO_ACC;
      else if (lb == LB_PUSH_ACC) word_op = OP_STACK_PUSH_ACC;
    end else if (IWORD[15:12] == NB_PORT_IN) begin
      word_op = OP_PORT_INPUT;
    end else if (IWORD[15:12] == NB_PORT_OUT) begin
      word_op = OP_PORT_OUTPUT;
    end else begin
      unique case (ub)
        UB_BR_NO_OV: word_op = OP_BRANCH_NO_OVERFLOW;
        UB_BR_ON_OV: word_op = OP_BRANCH_ON_OVERFLOW;
        UB_BR_NZ:    word_op = OP_BRANCH_NONZERO;
        UB_BR_Z:     word_op = OP_BRANCH_ZERO;
        UB_BLK_DD:   word_op = OP_BLOCK_COPY_DATA_TO_DATA;
        UB_BLK_PD:   word_op = OP_BLOCK_COPY_PROG_TO_DATA;
        UB_DMOVE:    word_op = OP_DATA_WORD_MOVE;
        UB_BTRG:     word_op = OP_BIT_TEST_BY_TREG;
        UB_SR0_LD:   word_op = OP_STATUS0_LOAD;
        UB_SR1_LD:   word_op = OP_STATUS1_LOAD;
        UB_SR0_SV:   word_op = OP_STATUS0_STORE;
        UB_SR1_SV:   word_op = OP_STATUS1_STORE;
        UB_POP_MEM:  word_op = OP_STACK_POP_TO_MEM;
        UB_PUSH_MEM: word_op = OP_STACK_PUSH_MEM;
        UB_REP_MEM:  word_op = OP_REPEAT_FROM_MEM;
        UB_REP_IMM:  word_op = OP_REPEAT_FROM_IMMEDIATE;
        default:     word_op = OP_NONE;
      endcase
    end
    word_two = (word_op inside {OP_BRANCH_NO_OVERFLOW, OP_BRANCH_ON_OVERFLOW,
                                OP_BRANCH_NONZERO, OP_BRANCH_ZERO,
                                OP_BLOCK_COPY_DATA_TO_DATA,
                                OP_BLOCK_COPY_PROG_TO_DATA});
  end

  // sequencing and decoded outputs
  always_comb begin
    state_nxt     = state_r;
    hold_op_nxt   = hold_op_r;
    hold_word_nxt = hold_word_r;
    valid_nxt     = 1'b0;
    op_nxt        = op_r;
    inc_nxt       = inc_r;
    ext_nxt       = ext_r;
    ind_nxt       = ind_r;
    oper_nxt      = oper_r;
    port_nxt      = port_r;
    imm_nxt       = imm_r;
    bitsel_nxt    = bitsel_r;
    take_nxt      = 1'b0;
    rep_nxt       = 1'b0;
    mode_nxt      = mode_r;
    unique case (state_r)
      ST_OPCODE: begin
        if (accept && word_two) begin
          state_nxt     = ST_EXTWORD;
          hold_op_nxt   = word_op;
          hold_word_nxt = IWORD;
        end else if (accept) begin
          valid_nxt  = 1'b1;
          op_nxt     = word_op;
          inc_nxt    = PC_INC_ONE;
          ext_nxt    = 16'h0000;
          ind_nxt    = am_indirect;
          oper_nxt   = am_operand;
          port_nxt   = IWORD[11:8];
          imm_nxt    = lb;
          bitsel_nxt = TREG_BIT;
          rep_nxt    = word_op inside {OP_REPEAT_FROM_MEM, OP_REPEAT_FROM_IMMEDIATE};
          unique case (word_op)
            OP_SERIAL_FORMAT_SET:      mode_nxt[MODE_FMT_BIT] = IWORD[0];
            OP_FRAME_SYNC_MODE_CLEAR:  mode_nxt[MODE_FSM_BIT] = 1'b0;
            OP_FRAME_SYNC_MODE_SET:    mode_nxt[MODE_FSM_BIT] = 1'b1;
            OP_TRANSMIT_MODE_CLEAR:    mode_nxt[MODE_TXM_BIT] = 1'b0;
            OP_TRANSMIT_MODE_SET:      mode_nxt[MODE_TXM_BIT] = 1'b1;
            OP_BLOCK_TO_DATA_SPACE:    mode_nxt[MODE_CFG_BIT] = 1'b0;
            OP_BLOCK_TO_PROGRAM_SPACE: mode_nxt[MODE_CFG_BIT] = 1'b1;
            default:                   mode_nxt = mode_r;
          endcase
        end
      end
      ST_EXTWORD: begin
        if (accept) begin
          state_nxt  = ST_OPCODE;
          valid_nxt  = 1'b1;
          op_nxt     = hold_op_r;
          inc_nxt    = PC_INC_TWO;
          ext_nxt    = IWORD;
          ind_nxt    = am_indirect;
          oper_nxt   = am_operand;
          port_nxt   = 4'h0;
          imm_nxt    = hold_word_r[7:0];
          bitsel_nxt = 4'h0;
          unique case (hold_op_r)
            OP_BRANCH_NO_OVERFLOW: take_nxt = !OV_FLAG;
            OP_BRANCH_ON_OVERFLOW: take_nxt = OV_FLAG;
            OP_BRANCH_NONZERO:     take_nxt = !ACC_ZERO;
            OP_BRANCH_ZERO:        take_nxt = ACC_ZERO;
            default:               take_nxt = 1'b0;
          endcase
        end
      end
    endcase
  end

  // register writes; a decode in a software clear cycle restarts the count at one
  always_comb begin
    ctrl_nxt  = ctrl_r;
    count_nxt = count_r;
    ctrl_nxt[CTRL_CLR_BIT] = 1'b0;
    if (wr_en && wr_addr == REG_CTRL_OFS) begin
      ctrl_nxt = wr_data[1:0];
    end
    if (ctrl_r[CTRL_CLR_BIT]) begin
      count_nxt = 32'h0000_0000;
    end
    if (valid_nxt) begin
      count_nxt = (ctrl_r[CTRL_CLR_BIT] ? 32'h0000_0000 : count_r) + 32'h0000_0001;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      REG_CTRL_OFS:  rd_data = {30'h0000_0000, 1'b0, ctrl_r[CTRL_EN_BIT]};
      REG_MODE_OFS:  rd_data = {28'h000_0000, mode_r};
      REG_LAST_OFS:  rd_data = {ext_r, 2'h0, inc_r, state_r, op_r, 6'h00};
      REG_COUNT_OFS: rd_data = count_r;
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r      <= CTRL_RST;
      mode_r      <= MODE_RST;
      count_r     <= 32'h0000_0000;
      state_r     <= ST_OPCODE;
      hold_op_r   <= OP_NONE;
      hold_word_r <= 16'h0000;
      valid_r     <= 1'b0;
      op_r        <= OP_NONE;
      inc_r       <= 2'h0;
      ext_r       <= 16'h0000;
      ind_r       <= 1'b0;
      oper_r      <= 7'h00;
      port_r      <= 4'h0;
      imm_r       <= 8'h00;
      bitsel_r    <= 4'h0;
      take_r      <= 1'b0;
      rep_r       <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      mode_r      <= mode_nxt;
      count_r     <= count_nxt;
      state_r     <= state_nxt;
      hold_op_r   <= hold_op_nxt;
      hold_word_r <= hold_word_nxt;
      valid_r     <= valid_nxt;
      op_r        <= op_nxt;
      inc_r       <= inc_nxt;
      ext_r       <= ext_nxt;
      ind_r       <= ind_nxt;
      oper_r      <= oper_nxt;
      port_r      <= port_nxt;
      imm_r       <= imm_nxt;
      bitsel_r    <= bitsel_nxt;
      take_r      <= take_nxt;
      rep_r       <= rep_nxt;
    end
  end

  assign DEC_VALID           = valid_r;
  assign DEC_OP              = op_r;
  assign DEC_PC_INC          = inc_r;
  assign DEC_EXT_WORD        = ext_r;
  assign DEC_INDIRECT        = ind_r;
  assign DEC_OPERAND         = oper_r;
  assign DEC_PORT            = port_r;
  assign DEC_IMM             = imm_r;
  assign DEC_BIT_SEL         = bitsel_r;
  assign BRANCH_TAKE         = take_r;
  assign REPEAT_LOAD         = rep_r;
  assign SERIAL_FORMAT       = mode_r[MODE_FMT_BIT];
  assign FRAME_SYNC_MODE     = mode_r[MODE_FSM_BIT];
  assign TRANSMIT_MODE       = mode_r[MODE_TXM_BIT];
  assign BLOCK_PROGRAM_SPACE = mode_r[MODE_CFG_BIT];

  // checks
  chk_ov_branch: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_EXTWORD && accept && hold_op_r == OP_BRANCH_NO_OVERFLOW)
    |=> (DEC_VALID && BRANCH_TAKE == !$past(OV_FLAG)))
    else $error("no-overflow branch took the wrong decision");

  chk_zero_branch: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_EXTWORD && accept && hold_op_r == OP_BRANCH_ZERO)
    |=> (DEC_VALID && BRANCH_TAKE == $past(ACC_ZERO)))
    else $error("zero branch took the wrong decision");

  chk_two_word_pc: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && word_two)
    ##1 (!DEC_VALID && state_r == ST_EXTWORD && accept)
    |=> (DEC_VALID && DEC_PC_INC == PC_INC_TWO && DEC_EXT_WORD == $past(IWORD)))
    else $error("two-word opcode did not advance by two");

  chk_format_load: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_PREFIX && lb[7:1] == LB_FORMAT_HI)
    |=> (SERIAL_FORMAT == $past(IWORD[0]) && DEC_PC_INC == PC_INC_ONE))
    else $error("serial format not loaded from bit zero");

  chk_port_select: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && IWORD[15:12] == NB_PORT_OUT)
    |=> (DEC_OP == OP_PORT_OUTPUT && DEC_PORT == $past(IWORD[11:8])))
    else $error("port output decoded with the wrong port");

  chk_frame_sync: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_PREFIX && lb == LB_FSM_SET)
    |=> FRAME_SYNC_MODE ##1 (FRAME_SYNC_MODE || $past(accept)))
    else $error("frame sync mode not set");

  chk_transmit_clr: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_PREFIX && lb == LB_TXM_CLR)
    |=> (!TRANSMIT_MODE && DEC_OP == OP_TRANSMIT_MODE_CLEAR))
    else $error("transmit mode not cleared");

  chk_bit_treg: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_BTRG)
    |=> (DEC_BIT_SEL == $past(TREG_BIT) && DEC_OPERAND == $past(IWORD[6:0])))
    else $error("bit test position not taken from T register");

  chk_block_space: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_PREFIX && lb == LB_CFG_PROG)
    |=> BLOCK_PROGRAM_SPACE)
    else $error("memory block not moved to program space");

  chk_repeat_imm: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && ub == UB_REP_IMM)
    |=> (REPEAT_LOAD && DEC_IMM == $past(lb)) ##1 (!REPEAT_LOAD || $past(accept)))
    else $error("immediate repeat count not loaded");

  chk_indirect_bit: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_r == ST_OPCODE && accept && !word_two)
    |=> (DEC_INDIRECT == $past(IWORD[7])))
    else $error("addressing mode does not follow bit seven");

endmodule

// >>> verification/dbd_prog_mem.sv
// program memory model streaming queued instruction words
module dbd_prog_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // instruction port
  input  wire logic        iword_ready,
  output logic      [15:0] iword,
  output logic             iword_valid,
  // pacing: one idle cycle before each word
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [$];
  logic        gap_r;
  task automatic push(input logic [15:0] w);
    mem_q.push_back(w);
  endtask
  // idle bus inverts the shown word every idle cycle, so the last word returns every other cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iword       <= 16'h0000;
      iword_valid <= 1'b0;
      gap_r       <= 1'b0;
    end else if (!iword_valid || iword_ready) begin
      if (mem_q.size() > 0 && (!slow || gap_r)) begin
        iword       <= mem_q.pop_front();
        iword_valid <= 1'b1;
        gap_r       <= 1'b0;
      end else begin
        iword       <= ~iword;
        iword_valid <= 1'b0;
        gap_r       <= 1'b1;
      end
    end
  end
endmodule

// >>> verification/dbd_decoder_tb.sv
// self-checking bench for the branch, io and control decoder
module dbd_decoder_tb import dbd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, IWORD_VALID, IWORD_READY;
  logic        OV_FLAG, ACC_ZERO, DEC_VALID, DEC_INDIRECT, BRANCH_TAKE, REPEAT_LOAD, slow;
  logic        SERIAL_FORMAT, FRAME_SYNC_MODE, TRANSMIT_MODE, BLOCK_PROGRAM_SPACE;
  logic [7:0]  HADDR, DEC_IMM;
  logic [1:0]  HTRANS, DEC_PC_INC;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA, rd;
  logic [15:0] IWORD, DEC_EXT_WORD;
  logic [4:0]  DEC_OP;
  logic [6:0]  DEC_OPERAND;
  logic [3:0]  TREG_BIT, DEC_PORT, DEC_BIT_SEL;
  int          n_errors, total_checks, n_dec;
  dbd_decoder u_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IWORD(IWORD), .IWORD_VALID(IWORD_VALID),
    .IWORD_READY(IWORD_READY), .OV_FLAG(OV_FLAG), .ACC_ZERO(ACC_ZERO), .TREG_BIT(TREG_BIT),
    .DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP), .DEC_PC_INC(DEC_PC_INC), .DEC_IMM(DEC_IMM),
    .DEC_EXT_WORD(DEC_EXT_WORD), .DEC_INDIRECT(DEC_INDIRECT), .DEC_OPERAND(DEC_OPERAND),
    .DEC_PORT(DEC_PORT), .DEC_BIT_SEL(DEC_BIT_SEL), .BRANCH_TAKE(BRANCH_TAKE),
    .REPEAT_LOAD(REPEAT_LOAD), .SERIAL_FORMAT(SERIAL_FORMAT), .TRANSMIT_MODE(TRANSMIT_MODE),
    .FRAME_SYNC_MODE(FRAME_SYNC_MODE), .BLOCK_PROGRAM_SPACE(BLOCK_PROGRAM_SPACE));
  dbd_prog_mem u_mem (.clk(CLK), .rst_n(RST_N), .iword_ready(IWORD_READY), .iword(IWORD),
    .iword_valid(IWORD_VALID), .slow(slow));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a wait that runs out of its bound ends the run as a failure
  task automatic give_up(input logic late);
    if (late) begin
      n_errors++;
      $display("Error at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR  <= a;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 40);
    give_up(n >= 40);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 40);
    give_up(n >= 40);
    rd = HRDATA;
    chk(HRESP, 1'b0);
  endtask
  // waits for the next decode pulse, then compares every decoded field
  task automatic check(input logic [15:0] w, input dbd_op_type op,
                       input logic [15:0] ext = 16'h0000, input logic take = 1'b0);
    logic two;
    int   n;
    two = (w[15:12] == 4'hF);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (DEC_VALID !== 1'b1 && n < 40);
    chk(n < 40, 1'b1);
    give_up(n >= 40);
    n_dec++;
    chk(DEC_OP, op);
    chk(DEC_PC_INC, two ? PC_INC_TWO : PC_INC_ONE);
    chk(DEC_EXT_WORD, two ? ext : 16'h0000);
    chk({DEC_INDIRECT, DEC_OPERAND}, w[7:0]);
    chk(DEC_IMM, w[7:0]);
    chk(DEC_PORT, two ? 4'h0 : w[11:8]);
    chk(DEC_BIT_SEL, two ? 4'h0 : TREG_BIT);
    chk(BRANCH_TAKE, take);
    chk(REPEAT_LOAD, op inside {OP_REPEAT_FROM_MEM, OP_REPEAT_FROM_IMMEDIATE});
    @(posedge CLK);
  endtask
  task automatic run(input logic [15:0] w, input dbd_op_type op,
                     input logic [15:0] ext = 16'h0000, input logic take = 1'b0);
    u_mem.push(w);
    if (w[15:12] == 4'hF) u_mem.push(ext);
    check(w, op, ext, take);
  endtask
  initial begin
    {n_errors, total_checks, n_dec} = '0;
    {RST_N, HSEL, HTRANS, HWRITE, HADDR, HWDATA, OV_FLAG, ACC_ZERO, slow} = '0;
    HSIZE    = 3'b010;
    TREG_BIT = 4'h9;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    ahb(1'b0, REG_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    run(16'hF785, OP_BRANCH_NO_OVERFLOW, 16'h1234, 1'b1);
    OV_FLAG <= 1'b1;
    run(16'hF785, OP_BRANCH_NO_OVERFLOW, 16'h0042);
    run(16'hF080, OP_BRANCH_ON_OVERFLOW, 16'h0043, 1'b1);
    OV_FLAG <= 1'b0;
    run(16'hF080, OP_BRANCH_ON_OVERFLOW, 16'h0044);
    run(16'hF580, OP_BRANCH_NONZERO, 16'h0045, 1'b1);
    run(16'hF680, OP_BRANCH_ZERO, 16'h0046);
    ACC_ZERO <= 1'b1;
    run(16'hF580, OP_BRANCH_NONZERO, 16'h0047);
    slow <= 1'b1;
    run(16'hF680, OP_BRANCH_ZERO, 16'hFFFF, 1'b1);
    run(16'hFD81, OP_BLOCK_COPY_DATA_TO_DATA, 16'h0300);
    run(16'hFC05, OP_BLOCK_COPY_PROG_TO_DATA, 16'hABCD);
    slow <= 1'b0;
    run(16'h5685, OP_DATA_WORD_MOVE);
    run(16'hCE0F, OP_SERIAL_FORMAT_SET);
    chk(SERIAL_FORMAT, 1'b1);
    run(16'hCE0E, OP_SERIAL_FORMAT_SET);
    chk(SERIAL_FORMAT, 1'b0);
    run(16'h8A12, OP_PORT_INPUT);
    run(16'hE3F0, OP_PORT_OUTPUT);
    run(16'hCE37, OP_FRAME_SYNC_MODE_SET);
    run(16'hCE21, OP_TRANSMIT_MODE_SET);
    run(16'hCE05, OP_BLOCK_TO_PROGRAM_SPACE);
    chk({BLOCK_PROGRAM_SPACE, TRANSMIT_MODE, FRAME_SYNC_MODE}, 3'b111);
    ahb(1'b0, REG_MODE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000E);
    run(16'hCE36, OP_FRAME_SYNC_MODE_CLEAR);
    run(16'hCE20, OP_TRANSMIT_MODE_CLEAR);
    run(16'hCE04, OP_BLOCK_TO_DATA_SPACE);
    chk({BLOCK_PROGRAM_SPACE, TRANSMIT_MODE, FRAME_SYNC_MODE}, 3'b000);
    run(16'h5701, OP_BIT_TEST_BY_TREG);
    run(16'h5003, OP_STATUS0_LOAD);
    run(16'h5181, OP_STATUS1_LOAD);
    run(16'h7802, OP_STATUS0_STORE);
    run(16'h7983, OP_STATUS1_STORE);
    run(16'hCE1D, OP_STACK_POP_TO_ACC);
    run(16'h7A11, OP_STACK_POP_TO_MEM);
    run(16'hCE1C, OP_STACK_PUSH_ACC);
    run(16'h5422, OP_STACK_PUSH_MEM);
    run(16'h4B44, OP_REPEAT_FROM_MEM);
    run(16'h5500, OP_NONE);
    $display("decode table done");
    ahb(1'b1, REG_CTRL_OFS, 32'h0000_0000);
    u_mem.push(16'hCBFF);
    u_mem.push(16'hF7FE);
    u_mem.push(16'h0077);
    repeat (6) @(negedge CLK) chk({DEC_VALID, IWORD_READY}, 2'b00);
    @(posedge CLK);
    ahb(1'b1, REG_CTRL_OFS, 32'h0000_0001);
    check(16'hCBFF, OP_REPEAT_FROM_IMMEDIATE);
    check(16'hF7FE, OP_BRANCH_NO_OVERFLOW, 16'h0077, 1'b1);
    ahb(1'b0, REG_COUNT_OFS, 32'h0000_0000);
    chk(rd, n_dec);
    ahb(1'b1, REG_CTRL_OFS, 32'h0000_0003);
    // the clear bit acts on the count one cycle after the write lands
    @(posedge CLK);
    ahb(1'b0, REG_COUNT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("stall and register test done");
    end_of_test();
  end
endmodule
